// ### rtl/ti_top.sv
// Function
// [R01] low limit word at 8Ah upper, 8Bh lower
// [R02] high limit word at 8Ch upper, 8Dh lower
// [R03] flags for below and above limit crossings
// [R04] flags for both channels' data-ready events
// [R05] flags stay set until software clears
// [R06] writing one clears a flag, zero keeps
// [R07] interrupt low while any flag set
// [R08] delay field, reset zero
// [R09] two-bit code picks test tone frequency
// [R10] dead time field, reset one
// [R11] host keeps modulator timing at one; the testbench writes other values for its tone checks
// [R12] host leaves register 90h alone
// [R13] persistence code needs 1 to 128 samples
// [R14] select bit routes limits to channel
// [R15] enable bits gate each flag
// [R16] pointer advances after every read byte
// [R17] below low or above high for persistence
`timescale 1ns/100ps
`default_nettype none
module ti_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial bus, open drain data
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // measurement results
  input wire logic [15:0] bs_result,
  input wire logic bs_valid,
  input wire logic [15:0] als_result,
  input wire logic als_valid,
  // interrupt pad and modulator settings
  output logic int_n,
  output logic test_tone,
  output logic [2:0] mod_delay,
  output logic [2:0] mod_dead_time
);
  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
    $error("ti_top: bus address is reserved");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  typedef struct packed {
    ti_pkg::ti_i2c_e st;
    logic scl_p;
    logic sda_p;
    logic oe_n;
    logic rw;
    logic first;
    logic ack;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] ctl;
    logic [7:0] mod;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [3:0] flags;
    logic int_n;
    logic tone;
    logic [8:0] tcnt;
  } ti_top_s;

  localparam ti_top_s RST_S = '{st: ti_pkg::ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, oe_n: 1'b1,
    ptr: ti_pkg::PTR_RST, ctl: ti_pkg::CTL_RST, mod: ti_pkg::MOD_RST, lo: ti_pkg::LIM_RST,
    hi: ti_pkg::LIM_RST, int_n: 1'b1, default: '0};

  ti_top_s s, n;
  ti_cmp_if #(.W(16)) cif ();
  logic start, stop, rise, fall, wr_fire;
  logic [3:0] ev, clr;
  logic [8:0] half;

  // bus conditions from the previous and present pin levels
  assign start = s.scl_p & scl & s.sda_p & ~sda_i;
  assign stop = s.scl_p & scl & ~s.sda_p & sda_i;
  assign rise = ~s.scl_p & scl;
  assign fall = s.scl_p & ~scl;
  // a data byte after the pointer byte lands in the register at ptr
  assign wr_fire = fall & (s.st == ti_pkg::ST_WR) & (s.bitcnt == 4'h8) & ~s.first;

  // limit comparison follows the selected channel
  assign cif.smp_vld = s.ctl[ti_pkg::CTL_SEL] ? als_valid : bs_valid; // see [R14]
  assign cif.smp_val = s.ctl[ti_pkg::CTL_SEL] ? als_result : bs_result; // see [R14]
  assign cif.lo_lim = s.lo;
  assign cif.hi_lim = s.hi;
  assign cif.persist_code = s.ctl[ti_pkg::CTL_PER_LSB+:3]; // see [R13]

  // hardware events, each gated by its enable
  assign ev[ti_pkg::FLG_BS] = bs_valid & s.ctl[ti_pkg::CTL_BS_EN]; // see [R04] [R15]
  assign ev[ti_pkg::FLG_ALS] = als_valid & s.ctl[ti_pkg::CTL_ALS_EN]; // see [R04] [R15]
  assign ev[ti_pkg::FLG_LOW] = cif.lo_hit & s.ctl[ti_pkg::CTL_LIM_EN]; // see [R03] [R15]
  assign ev[ti_pkg::FLG_HIGH] = cif.hi_hit & s.ctl[ti_pkg::CTL_LIM_EN]; // see [R03] [R15]
  assign clr = (wr_fire && s.ptr == ti_pkg::ADR_FLAGS) ? s.shreg[3:0] : 4'h0; // see [R06]

  // tone half period shrinks by a power of two per code step
  assign half = 9'(ti_pkg::TONE_HALF_CYC) >> s.mod[ti_pkg::MOD_FRQ_LSB+:2]; // see [R09]

  ti_persist #(.W(16)) u_persist (
    .clk(clk),
    .rst(rst),
    .cif(cif)
  );

  function automatic logic [7:0] rd_reg(input ti_top_s r);
    logic [7:0] v;
    v = 8'h00;
    unique case (r.ptr)
      ti_pkg::ADR_CTL: v = r.ctl;
      ti_pkg::ADR_LO_UP: v = r.lo[15:8];
      ti_pkg::ADR_LO_DN: v = r.lo[7:0];
      ti_pkg::ADR_HI_UP: v = r.hi[15:8];
      ti_pkg::ADR_HI_DN: v = r.hi[7:0];
      ti_pkg::ADR_FLAGS: v = {4'h0, r.flags};
      ti_pkg::ADR_MOD: v = r.mod;
      default: v = 8'h00; // reserved 90h and unmapped read as zero, see [R12]
    endcase
    return v;
  endfunction

  // next state: bus slave, register writes, flags, tone divider
  always_comb begin
    n = s;
    n.scl_p = scl;
    n.sda_p = sda_i;
    // set wins over a clear in the same cycle
    n.flags = (s.flags & ~clr) | ev; // see [R05] [R06]
    n.int_n = ~|n.flags; // see [R07]
    if (s.tcnt + 9'h001 >= half) begin
      n.tcnt = 9'h000;
      n.tone = ~s.tone; // see [R09]
    end else begin
      n.tcnt = s.tcnt + 9'h001;
    end
    if (wr_fire) begin
      unique case (s.ptr)
        ti_pkg::ADR_CTL: n.ctl = s.shreg;
        ti_pkg::ADR_LO_UP: n.lo[15:8] = s.shreg; // see [R01]
        ti_pkg::ADR_LO_DN: n.lo[7:0] = s.shreg; // see [R01]
        ti_pkg::ADR_HI_UP: n.hi[15:8] = s.shreg; // see [R02]
        ti_pkg::ADR_HI_DN: n.hi[7:0] = s.shreg; // see [R02]
        ti_pkg::ADR_MOD: n.mod = s.shreg; // see [R08] [R10]
        default: ; // flags handled above, others ignore writes
      endcase
    end
    // start and stop override any byte in flight
    if (start) begin
      n.st = ti_pkg::ST_ADDR;
      n.bitcnt = 4'h0;
      n.oe_n = 1'b1;
    end else if (stop) begin
      n.st = ti_pkg::ST_IDLE;
      n.oe_n = 1'b1;
    end else begin
      unique case (s.st)
        ti_pkg::ST_IDLE: ;
        ti_pkg::ST_ADDR, ti_pkg::ST_WR: begin
          if (rise) begin
            n.shreg = {s.shreg[6:0], sda_i};
            n.bitcnt = s.bitcnt + 4'h1;
          end else if (fall && s.bitcnt == 4'h8) begin
            if (s.st == ti_pkg::ST_WR) begin
              n.st = ti_pkg::ST_WACK;
              n.oe_n = 1'b0;
              n.first = 1'b0;
              n.ptr = s.first ? s.shreg : s.ptr + 8'h01;
            end else if (s.shreg[7:1] == DEV_ADDR) begin
              n.st = ti_pkg::ST_AACK;
              n.oe_n = 1'b0;
              n.rw = s.shreg[0];
              n.first = ~s.shreg[0];
            end else begin
              n.st = ti_pkg::ST_IDLE; // not our address
            end
          end
        end
        ti_pkg::ST_AACK, ti_pkg::ST_WACK: begin
          if (fall) begin
            n.bitcnt = 4'h0;
            if (s.st == ti_pkg::ST_AACK && s.rw) begin
              n.st = ti_pkg::ST_RD;
              n.shreg = rd_reg(s);
              n.oe_n = n.shreg[7];
            end else begin
              n.st = ti_pkg::ST_WR;
              n.oe_n = 1'b1;
            end
          end
        end
        ti_pkg::ST_RD: begin
          if (fall) begin
            if (s.bitcnt == 4'h7) begin
              n.st = ti_pkg::ST_RACK;
              n.oe_n = 1'b1;
              n.ptr = s.ptr + 8'h01; // see [R16]
            end else begin
              n.shreg = {s.shreg[6:0], 1'b0};
              n.oe_n = s.shreg[6];
              n.bitcnt = s.bitcnt + 4'h1;
            end
          end
        end
        ti_pkg::ST_RACK: begin
          if (rise) begin
            n.ack = ~sda_i;
          end else if (fall) begin
            if (s.ack) begin
              n.st = ti_pkg::ST_RD;
              n.bitcnt = 4'h0;
              n.shreg = rd_reg(s);
              n.oe_n = n.shreg[7];
            end else begin
              n.st = ti_pkg::ST_IDLE; // master ended the burst
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  // pins and settings straight from state; the pad only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n = s.oe_n;
  assign int_n = s.int_n;
  assign test_tone = s.tone;
  assign mod_delay = s.mod[ti_pkg::MOD_DLY_LSB+:3];
  assign mod_dead_time = s.mod[ti_pkg::MOD_DEAD_LSB+:3];

  a_int_follows_flags: assert property (s.flags != 4'h0 |-> !int_n) // see [R07]
    else $error("interrupt released while a flag is set");
  a_int_release: assert property (s.flags == 4'h0 |-> int_n) // see [R07]
    else $error("interrupt held with no flag set");
  a_flag_sticky: assert property ( // see [R05]
    !(wr_fire && s.ptr == ti_pkg::ADR_FLAGS) |=> ($past(s.flags) & ~s.flags) == 4'h0)
    else $error("flag dropped without a clearing write");
  a_w1c_clear: assert property ( // see [R06]
    wr_fire && s.ptr == ti_pkg::ADR_FLAGS && s.shreg[ti_pkg::FLG_LOW] && !ev[ti_pkg::FLG_LOW]
    |=> !s.flags[ti_pkg::FLG_LOW])
    else $error("written one did not clear flag");
  a_w1c_keep: assert property ( // see [R06]
    wr_fire && s.ptr == ti_pkg::ADR_FLAGS && !s.shreg[ti_pkg::FLG_HIGH] && s.flags[ti_pkg::FLG_HIGH]
    |=> s.flags[ti_pkg::FLG_HIGH])
    else $error("written zero cleared flag");
  a_low_limit_wr: assert property ( // see [R01]
    wr_fire && s.ptr == ti_pkg::ADR_LO_UP |=> s.lo[15:8] == $past(s.shreg))
    else $error("low limit upper byte not stored");
  a_high_limit_wr: assert property ( // see [R02]
    wr_fire && s.ptr == ti_pkg::ADR_HI_DN |=> s.hi[7:0] == $past(s.shreg))
    else $error("high limit lower byte not stored");
  a_mod_stable: assert property ( // see [R08] [R10]
    !(wr_fire && s.ptr == ti_pkg::ADR_MOD) |=> $stable(s.mod))
    else $error("modulator timing changed without a write");
  a_bs_gate: assert property ( // see [R15]
    !s.ctl[ti_pkg::CTL_BS_EN] && !s.flags[ti_pkg::FLG_BS] |=> !s.flags[ti_pkg::FLG_BS])
    else $error("disabled data-ready flag was set");
  a_ptr_advance: assert property ( // see [R16]
    s.st == ti_pkg::ST_RD && fall && s.bitcnt == 4'h7 |=> s.ptr == $past(s.ptr) + 8'h01)
    else $error("pointer did not advance after read byte");
  a_tone_hold: assert property ($changed(s.tone) |=> $stable(s.tone) [*8]) // see [R09]
    else $error("test tone half period too short");
  a_lim_route: assert property (s.ctl[ti_pkg::CTL_SEL] |-> cif.smp_vld == als_valid) // see [R14]
    else $error("limits not routed to ambient channel");

  c_flag_cleared: cover property (s.flags != 4'h0 ##1 s.flags == 4'h0);
  c_read_burst: cover property (s.st == ti_pkg::ST_RACK && s.ack ##[1:40] s.st == ti_pkg::ST_RD);
  c_fast_tone: cover property (s.mod[ti_pkg::MOD_FRQ_LSB+:2] == 2'h3 && $changed(s.tone));
endmodule
`default_nettype wire

// ### rtl/ti_pkg.sv
`default_nettype none
package ti_pkg;
  // register map
  localparam logic [7:0] ADR_CTL = 8'h89;
  localparam logic [7:0] ADR_LO_UP = 8'h8a;
  localparam logic [7:0] ADR_LO_DN = 8'h8b;
  localparam logic [7:0] ADR_HI_UP = 8'h8c;
  localparam logic [7:0] ADR_HI_DN = 8'h8d;
  localparam logic [7:0] ADR_FLAGS = 8'h8e;
  localparam logic [7:0] ADR_MOD = 8'h8f;
  localparam logic [7:0] ADR_RSVD = 8'h90;
  // event flag bit positions
  localparam int FLG_HIGH = 0;
  localparam int FLG_LOW = 1;
  localparam int FLG_ALS = 2;
  localparam int FLG_BS = 3;
  // interrupt control bit positions
  localparam int CTL_SEL = 0;
  localparam int CTL_LIM_EN = 1;
  localparam int CTL_ALS_EN = 2;
  localparam int CTL_BS_EN = 3;
  localparam int CTL_PER_LSB = 5;
  // modulator timing field positions
  localparam int MOD_DEAD_LSB = 0;
  localparam int MOD_FRQ_LSB = 3;
  localparam int MOD_DLY_LSB = 5;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] MOD_RST = 8'h01;
  localparam logic [15:0] LIM_RST = 16'h0000;
  localparam logic [7:0] PTR_RST = 8'h80;
  // timing: half period of the slowest test tone in clock cycles
  localparam int CLK_HZ = 250_000_000;
  localparam int TONE_BASE_HZ = 390_625;
  localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_BASE_HZ);
  // serial slave states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR = 7'h08,
    ST_WACK = 7'h10,
    ST_RD = 7'h20,
    ST_RACK = 7'h40
  } ti_i2c_e;
endpackage
`default_nettype wire

// ### rtl/ti_cmp_if.sv
`timescale 1ns/100ps
`default_nettype none
// sample and limits toward the persistence checker, hits back
interface ti_cmp_if #(parameter int W = 16);
  logic smp_vld;
  logic [W-1:0] smp_val;
  logic [W-1:0] lo_lim;
  logic [W-1:0] hi_lim;
  logic [2:0] persist_code;
  logic lo_hit;
  logic hi_hit;
  modport ctrl (output smp_vld, smp_val, lo_lim, hi_lim, persist_code, input lo_hit, hi_hit);
  modport cmp (input smp_vld, smp_val, lo_lim, hi_lim, persist_code, output lo_hit, hi_hit);
endinterface
`default_nettype wire

// ### rtl/ti_persist.sv
`timescale 1ns/100ps
`default_nettype none
module ti_persist #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // comparison channel
  ti_cmp_if.cmp cif
);
  if (W < 1 || W > 32) begin : g_bad_width
    $error("ti_persist: sample width out of range");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  typedef struct packed {
    logic [7:0] lo_cnt;
    logic [7:0] hi_cnt;
    logic lo_hit;
    logic hi_hit;
  } ti_per_s;

  ti_per_s s, n;
  logic [8:0] need;

  // 1 << code consecutive samples are needed
  assign need = 9'h001 << cif.persist_code; // see [R13]

  // run lengths restart after a hit so a steady level hits again every 1 << code samples
  always_comb begin
    n = s;
    n.lo_hit = 1'b0;
    n.hi_hit = 1'b0;
    if (cif.smp_vld) begin
      if (cif.smp_val < cif.lo_lim) begin // see [R17]
        if ({1'b0, s.lo_cnt} + 9'h001 >= need) begin
          n.lo_hit = 1'b1;
          n.lo_cnt = 8'h00;
        end else begin
          n.lo_cnt = s.lo_cnt + 8'h01;
        end
      end else begin
        n.lo_cnt = 8'h00;
      end
      if (cif.smp_val > cif.hi_lim) begin // see [R17]
        if ({1'b0, s.hi_cnt} + 9'h001 >= need) begin
          n.hi_hit = 1'b1;
          n.hi_cnt = 8'h00;
        end else begin
          n.hi_cnt = s.hi_cnt + 8'h01;
        end
      end else begin
        n.hi_cnt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign cif.lo_hit = s.lo_hit;
  assign cif.hi_hit = s.hi_hit;

  a_persist_single: assert property ( // see [R13]
    cif.persist_code == 3'h0 && cif.smp_vld && cif.smp_val < cif.lo_lim |=> cif.lo_hit)
    else $error("single-count low crossing did not hit");
  a_persist_wait: assert property ( // see [R17]
    cif.persist_code == 3'h1 && s.hi_cnt == 8'h00 && cif.smp_vld |=> !cif.hi_hit)
    else $error("high hit raised before second sample");
  c_persist_two: cover property (
    cif.persist_code == 3'h1 ##1 cif.hi_hit);
endmodule
`default_nettype wire

// ### test/ti_host.sv
`timescale 1ns/100ps
`default_nettype none
// stand-in for the host controller; every change lands just after a falling clk edge
module ti_host #(
  parameter int HALF = 8 // clk cycles per scl phase, slow enough for the slave's sampling
) (
  // clock
  input wire logic clk,
  // serial bus, open drain: sda_rel low pulls the line
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // idle bus from time zero
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one scl phase
  task automatic ph();
    repeat (HALF) @(negedge clk);
  endtask
  // start, also a repeated start when entered with scl low
  task automatic start();
    sda_rel = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_rel = 1'b0;
    ph();
    scl = 1'b0;
  endtask
  // stop, entered with scl low
  task automatic stop();
    sda_rel = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_rel = 1'b1;
    ph();
  endtask
  // one bit out, the line level sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_rel = b;
    ph();
    scl = 1'b1;
    repeat (HALF / 2) @(negedge clk);
    r = sda;
    repeat (HALF - HALF / 2) @(negedge clk);
    scl = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(ack_in, r);
    ack = ~r;
  endtask
  // address byte alone, reports whether the slave answered
  task automatic ping(input logic [6:0] dev, output logic ack);
    logic [7:0] q;
    start();
    byte_x({dev, 1'b0}, 1'b1, q, ack);
    stop();
  endtask
  // pointer byte then data bytes, pointer steps after each
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d[$]);
    logic [7:0] q;
    logic k;
    start();
    byte_x({dev, 1'b0}, 1'b1, q, k);
    byte_x(a, 1'b1, q, k);
    foreach (d[i]) byte_x(d[i], 1'b1, q, k);
    stop();
  endtask
  // pointer set, repeated start, n bytes read, last one refused
  task automatic rd(input logic [6:0] dev, input logic [7:0] a, input int n, output logic [7:0] q[$]);
    logic [7:0] b;
    logic k;
    q = {};
    start();
    byte_x({dev, 1'b0}, 1'b1, b, k);
    byte_x(a, 1'b1, b, k);
    start();
    byte_x({dev, 1'b1}, 1'b1, b, k);
    for (int i = 0; i < n; i++) begin
      byte_x(8'hff, i == n - 1, b, k);
      q.push_back(b);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ### test/ti_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ti_top_tb;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary bus address
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_rel, sda, sda_o, sda_oe_n, int_n, test_tone, ack;
  logic bs_valid, als_valid;
  logic [15:0] bs_result, als_result;
  logic [2:0] mod_delay, mod_dead_time;
  logic [7:0] q[$];
  int failures, checks_done, cycles;
  // pulled-up data line, low while either party pulls
  assign sda = sda_rel & (sda_oe_n | sda_o);
  always #2 clk = ~clk;
  ti_top #(.DEV_ADDR(DEV)) i_dut (.clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .bs_result(bs_result), .bs_valid(bs_valid), .als_result(als_result),
    .als_valid(als_valid), .int_n(int_n), .test_tone(test_tone), .mod_delay(mod_delay),
    .mod_dead_time(mod_dead_time));
  ti_host i_host (.clk(clk), .scl(scl), .sda_rel(sda_rel), .sda(sda));
  // verdict and end of run
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // case-equality compare, counted
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // read a run of registers and compare each byte
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp[$]);
    i_host.rd(DEV, a, exp.size(), q);
    foreach (exp[i]) chk({8'h00, q[i]}, {8'h00, exp[i]});
  endtask
  // n one-cycle samples on one channel; the other result sits between the limits
  task automatic smp(input logic ch, input logic [15:0] v, input int n);
    repeat (n) begin
      @(negedge clk);
      bs_result = ch ? 16'h0180 : v;
      als_result = ch ? v : 16'h0180;
      bs_valid = ~ch;
      als_valid = ch;
      @(negedge clk);
      bs_valid = 1'b0;
      als_valid = 1'b0;
    end
    repeat (4) @(negedge clk);
  endtask
  // third measured half period, so a code change settles first
  task automatic tone(input int exp);
    logic t0;
    int n;
    for (int j = 0; j < 3; j++) begin
      n = 0;
      t0 = test_tone;
      while (test_tone === t0 && n < 700) begin
        @(negedge clk);
        n++;
      end
    end
    chk(16'(n), 16'(exp));
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    failures = 0;
    checks_done = 0;
    cycles = 0;
    bs_valid = 1'b0;
    als_valid = 1'b0;
    bs_result = 16'h0000;
    als_result = 16'h0000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk({15'h0000, int_n}, 16'h0001); // pad released
    chk({13'h0000, mod_delay}, 16'h0000); // delay reset
    chk({13'h0000, mod_dead_time}, 16'h0001); // dead time reset
    rdchk(8'h8a, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}); // reset run
    rdchk(8'h80, '{8'h00}); // unmapped reads zero; 90h is never touched
    i_host.ping(DEV ^ 7'h01, ack);
    chk({15'h0000, ack}, 16'h0000); // foreign address refused
    i_host.ping(DEV, ack);
    chk({15'h0000, ack}, 16'h0001); // own address answered
    i_host.wr(DEV, 8'h8a, '{8'h12, 8'h34, 8'h56, 8'h78}); // limit words
    rdchk(8'h8a, '{8'h12, 8'h34, 8'h56, 8'h78}); // limit words
    // every tone code with odd delay and even dead time values
    for (int f = 0; f < 4; f++) begin
      i_host.wr(DEV, ti_pkg::ADR_MOD, '{{3'h5, 2'(f), 3'h2}}); // fields
      chk({13'h0000, mod_delay}, 16'h0005); // delay field
      chk({13'h0000, mod_dead_time}, 16'h0002); // dead time field
      rdchk(ti_pkg::ADR_MOD, '{{3'h5, 2'(f), 3'h2}}); // read back
      tone(320 >> f); // tone rate
    end
    i_host.wr(DEV, ti_pkg::ADR_MOD, '{8'h01}); // recommended setting
    chk({13'h0000, mod_dead_time}, 16'h0001); // back to default
    // data-ready events, gated one by one
    smp(1'b0, 16'h0180, 1);
    smp(1'b1, 16'h0180, 1);
    rdchk(8'h8e, '{8'h00}); // all gated off
    i_host.wr(DEV, 8'h89, '{8'h08});
    smp(1'b0, 16'h0180, 1);
    chk({15'h0000, int_n}, 16'h0000); // pad pulled
    smp(1'b1, 16'h0180, 1);
    rdchk(8'h8e, '{8'h08}); // bio only
    i_host.wr(DEV, 8'h89, '{8'h0c});
    smp(1'b1, 16'h0180, 1);
    rdchk(8'h8e, '{8'h0c}); // both ready flags
    i_host.wr(DEV, 8'h8e, '{8'h08}); // clear one flag
    rdchk(8'h8e, '{8'h04}); // zero bits kept
    chk({15'h0000, int_n}, 16'h0000); // one flag left
    i_host.wr(DEV, 8'h8e, '{8'h04}); // clear the last
    rdchk(8'h8e, '{8'h00}); // all clear
    chk({15'h0000, int_n}, 16'h0001); // released
    // limits 0100h and 0200h, four samples on the bio channel
    i_host.wr(DEV, 8'h8a, '{8'h01, 8'h00, 8'h02, 8'h00});
    i_host.wr(DEV, 8'h89, '{8'h42});
    smp(1'b1, 16'h00ff, 4);
    smp(1'b0, 16'h00ff, 3);
    smp(1'b0, 16'h0100, 1);
    smp(1'b0, 16'h00ff, 3);
    rdchk(8'h8e, '{8'h00}); // run broken by an equal sample
    smp(1'b0, 16'h00ff, 1);
    rdchk(8'h8e, '{8'h02}); // below flag
    i_host.wr(DEV, 8'h8e, '{8'h02}); // clear
    // longest persistence on the ambient channel
    i_host.wr(DEV, 8'h89, '{8'he3});
    smp(1'b0, 16'h0300, 1);
    smp(1'b1, 16'h0201, 127);
    rdchk(8'h8e, '{8'h00}); // one short of 128
    smp(1'b1, 16'h0201, 1);
    rdchk(8'h8e, '{8'h01}); // above flag
    smp(1'b1, 16'h0180, 2);
    rdchk(8'h8e, '{8'h01}); // sticky after calm samples
    i_host.wr(DEV, 8'h8e, '{8'h02}); // zero written over the set high flag
    rdchk(8'h8e, '{8'h01}); // high flag kept
    i_host.wr(DEV, 8'h8e, '{8'h01}); // clear it
    // two-sample persistence on the ambient channel
    i_host.wr(DEV, 8'h89, '{8'h23});
    rdchk(8'h89, '{8'h23}); // control read back
    smp(1'b1, 16'h0201, 1);
    rdchk(8'h8e, '{8'h00}); // one of two
    smp(1'b1, 16'h0201, 1);
    rdchk(8'h8e, '{8'h01}); // above flag after two
    chk({15'h0000, int_n}, 16'h0000); // pad pulled
    // reset in mid-run puts every register back
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk({15'h0000, int_n}, 16'h0001); // released by reset
    chk({13'h0000, mod_delay}, 16'h0000); // delay reset
    rdchk(8'h89, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}); // all reset
    end_of_test();
  end
endmodule
`default_nettype wire
